// File: rtl/hb_defines.svh
// timing values in ns and clock cycles for the half-bridge supervisor
`ifndef HB_DEFINES_SVH
`define HB_DEFINES_SVH
`define CLK_PERIOD_NS      10
`define SC_FILTER_NS       6000
`define SC_FILTER_CYC      (`SC_FILTER_NS / `CLK_PERIOD_NS)
`define OC_BLANK_NS        1500
`define OC_BLANK_CYC       (`OC_BLANK_NS / `CLK_PERIOD_NS)
`define OV_FILTER_NS       30000
`define OV_FILTER_CYC      (`OV_FILTER_NS / `CLK_PERIOD_NS)
`define UV_FILTER_NS       1000
`define UV_FILTER_CYC      (`UV_FILTER_NS / `CLK_PERIOD_NS)
`define DT_MIN_NS          200
`define DT_MIN_CYC         ((`DT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RES_CLEAR_NS       2000
`define RES_CLEAR_CYC      (`RES_CLEAR_NS / `CLK_PERIOD_NS)
`define RES_IGNORE_NS      500
`define RES_IGNORE_CYC     (`RES_IGNORE_NS / `CLK_PERIOD_NS)
`endif

// File: rtl/hb_pkg.sv
// types shared by the half-bridge supervisor files
package hb_pkg;
    typedef enum logic [1:0] {
        CODE_NONE  = 2'b00,
        CODE_OTOV  = 2'b01,
        CODE_UV    = 2'b11,
        CODE_SCOC  = 2'b10
    } fault_code_t;
endpackage

// File: rtl/hb_phase_if.sv
// interface carrying one half-bridge phase between supervisor and phase module
`timescale 1ns/1ns
interface hb_phase_if;
    logic hi_cmd;
    logic lo_cmd;
    logic gate_allow;
    logic hi_gate;
    logic lo_gate;
    logic hi_armed;
    logic lo_armed;
    modport sup   (output hi_cmd, output lo_cmd, output gate_allow,
                   input hi_gate, input lo_gate, input hi_armed, input lo_armed);
    modport phase (input hi_cmd, input lo_cmd, input gate_allow,
                   output hi_gate, output lo_gate, output hi_armed, output lo_armed);
endinterface

// File: rtl/hb_phase.sv
// one half-bridge phase: shoot-through lockout, dead time, monitor arming
`timescale 1ns/1ns
`include "hb_defines.svh"
module hb_phase
    import hb_pkg::*;
#(
    parameter int DT_W = 8
) (
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic [DT_W-1:0] dead_cycles,
    hb_phase_if.phase            ph
);
    logic [DT_W-1:0] dt_cnt_reg, dt_cnt_next;
    logic            hi_reg, hi_next;
    logic            lo_reg, lo_next;
    logic            want_hi, want_lo;

    // both on at once is dropped; the pair goes idle instead
    assign want_hi = ph.gate_allow && ph.hi_cmd && !ph.lo_cmd;
    assign want_lo = ph.gate_allow && ph.lo_cmd && !ph.hi_cmd;

    // a side may turn on only after both were off for the dead time
    always_comb begin
        hi_next     = 1'b0;
        lo_next     = 1'b0;
        dt_cnt_next = dt_cnt_reg;
        if (hi_reg || lo_reg) begin
            dt_cnt_next = '0;
            hi_next     = hi_reg && want_hi;
            lo_next     = lo_reg && want_lo;
        end else if (!want_hi && !want_lo) begin
            dt_cnt_next = '0;
        end else if (dt_cnt_reg >= dead_cycles) begin
            hi_next = want_hi;
            lo_next = want_lo;
        end else begin
            dt_cnt_next = dt_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dt_cnt_reg <= '0;
            hi_reg     <= 1'b0;
            lo_reg     <= 1'b0;
        end else begin
            dt_cnt_reg <= dt_cnt_next;
            hi_reg     <= hi_next;
            lo_reg     <= lo_next;
        end
    end

    assign ph.hi_gate  = hi_reg;
    assign ph.lo_gate  = lo_reg;
    // monitor only once the gate is really on, i.e. dead time expired
    assign ph.hi_armed = hi_reg && ph.hi_cmd;
    assign ph.lo_armed = lo_reg && ph.lo_cmd;
endmodule

// File: rtl/hb_fault_supervisor.sv
// three-phase gate driver protection and fault reporting top
`timescale 1ns/1ns
`include "hb_defines.svh"

// Summary of operation
// - drain-source over limit on an armed switch starts the short-circuit timer
// - short lasting 6 us turns all switches off and latches until enable reset
// - a switch is monitored only while commanded on and past dead time
// - detection level is a fixed factory option out of five levels
// - overcurrent comparator passes a 1.5 us blanking filter
// - overcurrent only warns; switches keep following commands
// - overcurrent warning clears when current falls or commutates to high side
// - dead time separates one switch off from its partner on
// - both switches of one bridge requested on is ignored
// - filtered pump undervoltage pulls all gates low, disables short monitoring
// - undervoltage recovery resumes the input pattern without reset
// - filtered supply overvoltage turns switches and pumps off until reset
// - overvoltage shutdown also reports the resulting undervoltage
// - overtemperature warns, keeps running, clears by itself
// - status pins: 00 none, 10 OT/OV, 11 UV, 01 SC/OC (a,b)
// - priority: short circuit, undervoltage, overvoltage, then OT and OC
// - no fault causes sleep; only the wake control input does
// - enable low for the reset time clears latches and switches off
// - while disabled only undervoltage and overtemperature are shown
// - enable low pulses of 0.5 us or less are no reset
module hb_fault_supervisor
    import hb_pkg::*;
#(
    parameter int DT_W          = 8,
    parameter int SC_FILTER_CYC = `SC_FILTER_CYC,
    parameter int OC_BLANK_CYC  = `OC_BLANK_CYC,
    parameter int OV_FILTER_CYC = `OV_FILTER_CYC,
    parameter int UV_FILTER_CYC = `UV_FILTER_CYC,
    parameter int RES_CLEAR_CYC = `RES_CLEAR_CYC
) (
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic [2:0]      gate_cmd_hi,
    input  wire logic [2:0]      gate_cmd_lo,
    input  wire logic [1:0]      bridge_enable_in,
    input  wire logic            wake_control_in,
    input  wire logic [DT_W-1:0] dead_time_set_pin,
    input  wire logic [2:0]      ds_trip_hi,
    input  wire logic [2:0]      ds_trip_lo,
    input  wire logic            overcurrent_limit_pin,
    input  wire logic [1:0]      pump_buffer_caps,
    input  wire logic            vs_over_sense,
    input  wire logic            bridge_supply_sense,
    input  wire logic            temp_over_sense,
    output logic      [2:0]      gate_out_hi,
    output logic      [2:0]      gate_out_lo,
    output logic                 pump_enable,
    output logic                 sleep_out,
    output logic                 fault_code_out_a,
    output logic                 fault_code_out_b
);
    // pins through the synchroniser
    localparam int NSYNC = 21;
    localparam int CW    = 16;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, clean_reg;
    logic [NSYNC-1:0] s1_next, s2_next, s3_next, clean_next;

    // same order as the unpacking below
    assign raw_in = {gate_cmd_hi, gate_cmd_lo, bridge_enable_in, wake_control_in,
                     ds_trip_hi, ds_trip_lo, overcurrent_limit_pin, pump_buffer_caps,
                     vs_over_sense, bridge_supply_sense, temp_over_sense};

    // a bit changes only once the second and third stage agree
    always_comb begin
        // stages shift one place per clock
        s1_next    = raw_in;
        s2_next    = s1_reg;
        s3_next    = s2_reg;
        clean_next = clean_reg;

        // a disagreeing pair keeps the old value
        for (int i = 0; i < NSYNC; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                clean_next[i] = s3_reg[i];
            end
        end
    end

    // synchroniser registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            clean_reg <= '0;
        end else begin
            s1_reg    <= s1_next;
            s2_reg    <= s2_next;
            s3_reg    <= s3_next;
            clean_reg <= clean_next;
        end
    end

    logic [2:0] c_hi, c_lo, c_dsh, c_dsl;
    logic [1:0] c_ena, c_pump;
    logic       c_wake, c_oc, c_vs, c_vdh, c_temp;

    // agreed pin values
    assign {c_hi, c_lo, c_ena, c_wake, c_dsh, c_dsl, c_oc, c_pump,
            c_vs, c_vdh, c_temp} = clean_reg;

    // ************************************************************
    // filter timers
    // ************************************************************
    // counters saturate, so they never wrap
    logic [CW-1:0] sc_cnt_reg, oc_cnt_reg, ov_cnt_reg, uv_cnt_reg, res_cnt_reg;
    logic [CW-1:0] sc_cnt_next, oc_cnt_next, ov_cnt_next, uv_cnt_next, res_cnt_next;
    logic          sc_latch_reg, ov_latch_reg, oc_warn_reg, uv_reg;
    logic          sc_latch_next, ov_latch_next, oc_warn_next, uv_next;
    logic          sc_raw, ov_raw, uv_raw, oc_raw, enabled, res_hit;
    logic [2:0]    armed_hi, armed_lo;

    // the comparator tripping on an armed switch is the short condition;
    // the level itself is fixed in the analog comparator, not here
    assign sc_raw  = |((c_dsh & armed_hi) | (c_dsl & armed_lo)) && !uv_reg;

    // either supply over its level
    assign ov_raw  = c_vs || c_vdh;

    // pump caps discharge when overvoltage shuts the pumps off
    assign uv_raw  = (|c_pump) || ov_latch_reg;

    // current through shunt only while a low side conducts
    assign oc_raw  = c_oc && (|gate_out_lo);

    // both enable lines high
    assign enabled = &c_ena;
    // enable low for the clear time
    assign res_hit = (res_cnt_reg >= CW'(RES_CLEAR_CYC));

    // counters drop to zero unless their condition holds
    always_comb begin
        sc_cnt_next   = '0;
        oc_cnt_next   = '0;
        ov_cnt_next   = '0;
        uv_cnt_next   = '0;
        res_cnt_next  = '0;
        sc_latch_next = sc_latch_reg;
        ov_latch_next = ov_latch_reg;
        oc_warn_next  = 1'b0;
        uv_next       = 1'b0;

        // short: armed trips count to the mark
        if (sc_raw) begin
            sc_cnt_next = (sc_cnt_reg >= CW'(SC_FILTER_CYC)) ? sc_cnt_reg
                                                              : sc_cnt_reg + 1'b1;
        end
        if (sc_raw && sc_cnt_reg >= CW'(SC_FILTER_CYC - 1)) begin
            sc_latch_next = 1'b1;
        end

        // overvoltage latches like a short
        if (ov_raw) begin
            ov_cnt_next = (ov_cnt_reg >= CW'(OV_FILTER_CYC)) ? ov_cnt_reg
                                                              : ov_cnt_reg + 1'b1;
        end
        if (ov_raw && ov_cnt_reg >= CW'(OV_FILTER_CYC - 1)) begin
            ov_latch_next = 1'b1;
        end

        // blanking hides short overshoot of the sensed current
        if (oc_raw) begin
            oc_cnt_next  = (oc_cnt_reg >= CW'(OC_BLANK_CYC)) ? oc_cnt_reg
                                                              : oc_cnt_reg + 1'b1;
            oc_warn_next = oc_warn_reg || (oc_cnt_reg >= CW'(OC_BLANK_CYC - 1));
        end

        // undervoltage holds only while its source is present: auto restart
        if (uv_raw) begin
            uv_cnt_next = (uv_cnt_reg >= CW'(UV_FILTER_CYC)) ? uv_cnt_reg
                                                              : uv_cnt_reg + 1'b1;
            uv_next     = uv_reg || (uv_cnt_reg >= CW'(UV_FILTER_CYC - 1));
        end

        // enable low: counting long lows; short ones never reach the mark
        if (!enabled) begin
            res_cnt_next = res_hit ? res_cnt_reg : res_cnt_reg + 1'b1;
        end

        // clearing follows detection in the same cycle, so a new fault
        // during reset would be masked; reset wins by design intent
        if (res_hit) begin
            sc_latch_next = 1'b0;
            ov_latch_next = 1'b0;
        end
    end

    // filter and latch registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sc_cnt_reg   <= '0;
            oc_cnt_reg   <= '0;
            ov_cnt_reg   <= '0;
            uv_cnt_reg   <= '0;
            res_cnt_reg  <= '0;
            sc_latch_reg <= 1'b0;
            ov_latch_reg <= 1'b0;
            oc_warn_reg  <= 1'b0;
            uv_reg       <= 1'b0;
        end else begin
            sc_cnt_reg   <= sc_cnt_next;
            oc_cnt_reg   <= oc_cnt_next;
            ov_cnt_reg   <= ov_cnt_next;
            uv_cnt_reg   <= uv_cnt_next;
            res_cnt_reg  <= res_cnt_next;
            sc_latch_reg <= sc_latch_next;
            ov_latch_reg <= ov_latch_next;
            oc_warn_reg  <= oc_warn_next;
            uv_reg       <= uv_next;
        end
    end

    // ************************************************************
    // phases
    // ************************************************************
    logic       allow;
    logic [DT_W-1:0] dead_cycles;
    logic [2:0] g_hi, g_lo;

    // overcurrent and overtemperature do not block the gates
    assign allow = enabled && !sc_latch_reg && !ov_latch_reg && !uv_reg;
    // resistor setting adds cycles on top of the fixed minimum
    // the sum is DT_W bits: a large setting wraps
    assign dead_cycles = DT_W'(`DT_MIN_CYC) + dead_time_set_pin;

    // one phase module per half bridge
    for (genvar p = 0; p < 3; p++) begin : g_phase
        hb_phase_if ph ();

        assign ph.hi_cmd     = c_hi[p];
        assign ph.lo_cmd     = c_lo[p];
        assign ph.gate_allow = allow;
        assign g_hi[p]       = ph.hi_gate;
        assign g_lo[p]       = ph.lo_gate;
        assign armed_hi[p]   = ph.hi_armed;
        assign armed_lo[p]   = ph.lo_armed;

        // all phases share one dead_cycles setting; each phase counts on its own
        hb_phase #(.DT_W(DT_W)) u_phase (
            .core_clk    (core_clk),
            .rst         (rst),
            .dead_cycles (dead_cycles),
            .ph          (ph)
        );
    end

    // ************************************************************
    // status outputs
    // ************************************************************
    // code, pump and sleep registers
    fault_code_t code_reg, code_next;
    logic        pump_reg, sleep_reg;

    // priority encoder of the active faults
    always_comb begin
        code_next = CODE_NONE;

        if (enabled) begin
            if (sc_latch_reg)      code_next = CODE_SCOC;
            else if (uv_reg)       code_next = CODE_UV;
            else if (ov_latch_reg) code_next = CODE_OTOV;
            else if (c_temp)       code_next = CODE_OTOV;
            else if (oc_warn_reg)  code_next = CODE_SCOC;
        end else begin
            // other faults stay hidden while disabled
            if (uv_reg)            code_next = CODE_UV;
            else if (c_temp)       code_next = CODE_OTOV;
        end
    end

    // registered so the pins never glitch
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            code_reg  <= CODE_NONE;
            pump_reg  <= 1'b0;
            sleep_reg <= 1'b0;
        end else begin
            code_reg  <= code_next;
            pump_reg  <= !ov_latch_reg;
            sleep_reg <= !c_wake;
        end
    end

    // pins straight from registers
    assign gate_out_hi      = g_hi;
    assign gate_out_lo      = g_lo;
    assign pump_enable      = pump_reg;
    assign sleep_out        = sleep_reg;
    assign fault_code_out_a = code_reg[0];
    assign fault_code_out_b = code_reg[1];
endmodule

// File: bench/hb_fault_chk.sv
// concurrent checks on the half-bridge supervisor ports
`timescale 1ns/1ns
module hb_fault_chk
    import hb_pkg::*;
#(
    parameter int DT_W          = 8,
    parameter int SC_FILTER_CYC = 600,
    parameter int OV_FILTER_CYC = 3000,
    parameter int UV_FILTER_CYC = 100
) (
    input wire logic            core_clk,
    input wire logic            rst,
    input wire logic [2:0]      gate_cmd_hi,
    input wire logic [2:0]      gate_cmd_lo,
    input wire logic [1:0]      bridge_enable_in,
    input wire logic            wake_control_in,
    input wire logic [DT_W-1:0] dead_time_set_pin,
    input wire logic [2:0]      ds_trip_hi,
    input wire logic [2:0]      ds_trip_lo,
    input wire logic            overcurrent_limit_pin,
    input wire logic [1:0]      pump_buffer_caps,
    input wire logic            vs_over_sense,
    input wire logic            bridge_supply_sense,
    input wire logic            temp_over_sense,
    input wire logic [2:0]      gate_out_hi,
    input wire logic [2:0]      gate_out_lo,
    input wire logic            pump_enable,
    input wire logic            sleep_out,
    input wire logic            fault_code_out_a,
    input wire logic            fault_code_out_b
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [15:0] sc_reg, sc_next, uv_reg, uv_next, ov_reg, ov_next;
    logic [15:0] hoff_reg, hoff_next, loff_reg, loff_next;
    // run lengths; off counters start full since gates were off through reset
    always_comb begin
        sc_next = (gate_out_lo[0] && ds_trip_lo[0]) ? sc_reg + 16'h1 : 16'h0;
        uv_next = (pump_buffer_caps != 2'h0) ? uv_reg + 16'h1 : 16'h0;
        ov_next = ((vs_over_sense || bridge_supply_sense) && bridge_enable_in == 2'h3) ?
                  ov_reg + 16'h1 : 16'h0;
        hoff_next = gate_out_hi[0] ? 16'h0 : hoff_reg + {15'h0, hoff_reg != 16'hFFFF};
        loff_next = gate_out_lo[0] ? 16'h0 : loff_reg + {15'h0, loff_reg != 16'hFFFF};
    end
    // counter registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sc_reg <= 16'h0;
            uv_reg <= 16'h0;
            ov_reg <= 16'h0;
            hoff_reg <= 16'hFFFF;
            loff_reg <= 16'hFFFF;
        end else begin
            sc_reg <= sc_next;
            uv_reg <= uv_next;
            ov_reg <= ov_next;
            hoff_reg <= hoff_next;
            loff_reg <= loff_next;
        end
    end
    // eight cycles covers the input synchroniser and the output register
    sequence seq_disabled;
        (bridge_enable_in != 2'h3) [*8];
    endsequence
    sequence seq_awake;
        wake_control_in [*8];
    endsequence
    a_no_shoot: assert property (!(|(gate_out_hi & gate_out_lo)))
        else $error("both gates of a bridge on");
    a_dead_hi: assert property ($rose(gate_out_hi[0]) |->
        loff_reg >= 16'(dead_time_set_pin) + 16'h14) else $error("high side on too early");
    a_dead_lo: assert property ($rose(gate_out_lo[0]) |->
        hoff_reg >= 16'(dead_time_set_pin) + 16'h14) else $error("low side on too early");
    a_dis_gates: assert property (seq_disabled |-> gate_out_hi == 3'h0 && gate_out_lo == 3'h0)
        else $error("gate on while disabled");
    a_dis_code: assert property (seq_disabled |-> !(!fault_code_out_a && fault_code_out_b))
        else $error("short or overcurrent shown while disabled");
    a_wake_sleep: assert property (seq_awake |-> !sleep_out)
        else $error("sleep without wake request");
    a_sc_trip: assert property (sc_reg <= 16'(SC_FILTER_CYC + 8))
        else $error("short not tripped in time");
    a_uv_off: assert property (uv_reg >= 16'(UV_FILTER_CYC + 8) |->
        gate_out_hi == 3'h0 && gate_out_lo == 3'h0 && fault_code_out_b)
        else $error("undervoltage not acted on");
    a_ov_pump: assert property (ov_reg >= 16'(OV_FILTER_CYC + 8) |->
        !pump_enable && gate_out_hi == 3'h0) else $error("overvoltage not acted on");
endmodule
bind hb_fault_supervisor hb_fault_chk #(.DT_W(DT_W), .SC_FILTER_CYC(SC_FILTER_CYC),
    .OV_FILTER_CYC(OV_FILTER_CYC), .UV_FILTER_CYC(UV_FILTER_CYC)) hb_fault_chk_i (
    .core_clk(core_clk), .rst(rst), .gate_cmd_hi(gate_cmd_hi), .gate_cmd_lo(gate_cmd_lo),
    .bridge_enable_in(bridge_enable_in), .wake_control_in(wake_control_in),
    .dead_time_set_pin(dead_time_set_pin), .ds_trip_hi(ds_trip_hi), .ds_trip_lo(ds_trip_lo),
    .overcurrent_limit_pin(overcurrent_limit_pin), .pump_buffer_caps(pump_buffer_caps),
    .vs_over_sense(vs_over_sense), .bridge_supply_sense(bridge_supply_sense),
    .temp_over_sense(temp_over_sense), .gate_out_hi(gate_out_hi), .gate_out_lo(gate_out_lo),
    .pump_enable(pump_enable), .sleep_out(sleep_out), .fault_code_out_a(fault_code_out_a),
    .fault_code_out_b(fault_code_out_b));

// File: bench/hb_host_model.sv
// host-side model issuing gate commands and enable levels
`timescale 1ns/1ns
module hb_host_model (
    input  wire logic       core_clk,
    output logic      [2:0] gate_cmd_hi,
    output logic      [2:0] gate_cmd_lo,
    output logic      [1:0] bridge_enable_in
);
    // enabled with every switch commanded off until the first command
    initial begin
        gate_cmd_hi = 3'h0;
        gate_cmd_lo = 3'h0;
        bridge_enable_in = 2'h3;
    end
    // changes land after a falling edge, well away from the sampling edge
    task automatic command(input logic [2:0] hi, input logic [2:0] lo);
        @(negedge core_clk);
        gate_cmd_hi = hi;
        gate_cmd_lo = lo;
    endtask
    // the caller decides how long a low enable stands: long clears, short does not
    task automatic set_enable(input logic [1:0] en);
        @(negedge core_clk);
        bridge_enable_in = en;
    endtask
endmodule

// File: bench/hb_fault_supervisor_tb.sv
// self-checking bench for the half-bridge fault supervisor
`timescale 1ns/1ns
module hb_fault_supervisor_tb;
    import hb_pkg::*;
    localparam int SC  = 12;
    localparam int OV  = 16;
    localparam int RES = 20;
    typedef struct {logic [1:0] code; logic [2:0] hi; logic [2:0] lo; logic p; logic s;} note_t;
    logic       core_clk, rst, wake_control_in, overcurrent_limit_pin, temp_over_sense;
    logic       vs_over_sense, bridge_supply_sense, pump_enable, sleep_out;
    logic       fault_code_out_a, fault_code_out_b;
    logic [2:0] gate_cmd_hi, gate_cmd_lo, ds_trip_hi, ds_trip_lo, gate_out_hi, gate_out_lo, r1, r2;
    logic [1:0] bridge_enable_in, pump_buffer_caps;
    logic [7:0] dead_time_set_pin;
    note_t      notes[$];
    note_t      nt;
    int         n_fail, checked, seed;
    hb_host_model hb_host_model_i (.core_clk(core_clk), .gate_cmd_hi(gate_cmd_hi),
        .gate_cmd_lo(gate_cmd_lo), .bridge_enable_in(bridge_enable_in));
    hb_fault_supervisor #(.SC_FILTER_CYC(SC), .OC_BLANK_CYC(8), .OV_FILTER_CYC(OV),
        .UV_FILTER_CYC(6), .RES_CLEAR_CYC(RES)) hb_fault_supervisor_i (.core_clk(core_clk),
        .rst(rst), .gate_cmd_hi(gate_cmd_hi), .gate_cmd_lo(gate_cmd_lo),
        .bridge_enable_in(bridge_enable_in), .wake_control_in(wake_control_in),
        .dead_time_set_pin(dead_time_set_pin), .ds_trip_hi(ds_trip_hi), .ds_trip_lo(ds_trip_lo),
        .overcurrent_limit_pin(overcurrent_limit_pin), .pump_buffer_caps(pump_buffer_caps),
        .vs_over_sense(vs_over_sense), .bridge_supply_sense(bridge_supply_sense),
        .temp_over_sense(temp_over_sense), .gate_out_hi(gate_out_hi), .gate_out_lo(gate_out_lo),
        .pump_enable(pump_enable), .sleep_out(sleep_out), .fault_code_out_a(fault_code_out_a),
        .fault_code_out_b(fault_code_out_b));
    // code enum holds the second status pin in its upper bit
    task automatic expect_out(input logic [1:0] c, input logic [2:0] h, input logic [2:0] l,
                              input logic p = 1'b1, input logic s = 1'b0);
        notes.push_back('{c, h, l, p, s});
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic conclude();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // watcher: compares the oldest note once outputs have settled past the edge
    initial begin
        forever begin
            @(posedge core_clk);
            #2;
            while (notes.size() > 0) begin
                nt = notes.pop_front();
                checked++;
                if ({fault_code_out_b, fault_code_out_a} !== nt.code || gate_out_hi !== nt.hi ||
                    gate_out_lo !== nt.lo || pump_enable !== nt.p || sleep_out !== nt.s) begin
                    $display("Error at %0t: outputs %b%b %b %b %b %b, note %b %b %b %b %b",
                             $time, fault_code_out_b, fault_code_out_a, gate_out_hi,
                             gate_out_lo, pump_enable, sleep_out, nt.code, nt.hi, nt.lo, nt.p,
                             nt.s);
                    n_fail++;
                end
            end
        end
    end
    // watchdog sized well beyond the roughly 1400 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        $display("Error at %0t: run did not finish", $time);
        conclude();
    end
    initial begin
        seed = 46742;
        n_fail = 0;
        checked = 0;
        rst = 1'b1;
        {wake_control_in, overcurrent_limit_pin, temp_over_sense} = 3'h4;
        {vs_over_sense, bridge_supply_sense, pump_buffer_caps} = 4'h0;
        ds_trip_hi = 3'h0;
        ds_trip_lo = 3'h0;
        dead_time_set_pin = 8'($unsigned($random(seed)) % 8);
        repeat (5) @(posedge core_clk);
        step(1);
        rst = 1'b0;
        // random patterns, overlapping requests included
        for (int k = 0; k < 6; k++) begin
            r1 = 3'($random(seed));
            r2 = 3'($random(seed));
            temp_over_sense = 1'($random(seed));
            hb_host_model_i.command(r1, r2);
            step(60);
            expect_out(temp_over_sense ? CODE_OTOV : CODE_NONE, r1 & ~r2, r2 & ~r1);
        end
        temp_over_sense = 1'b0;
        hb_host_model_i.command(3'h1, 3'h2);
        step(60);
        temp_over_sense = 1'b1;
        step(20);
        expect_out(CODE_OTOV, 3'h1, 3'h2);
        temp_over_sense = 1'b0;
        step(20);
        expect_out(CODE_NONE, 3'h1, 3'h2);
        // a short overshoot is blanked, a long one only warns
        overcurrent_limit_pin = 1'b1;
        step(4);
        overcurrent_limit_pin = 1'b0;
        step(20);
        expect_out(CODE_NONE, 3'h1, 3'h2);
        overcurrent_limit_pin = 1'b1;
        step(30);
        expect_out(CODE_SCOC, 3'h1, 3'h2);
        overcurrent_limit_pin = 1'b0;
        step(20);
        expect_out(CODE_NONE, 3'h1, 3'h2);
        overcurrent_limit_pin = 1'b1;
        hb_host_model_i.command(3'h3, 3'h0);
        step(60);
        expect_out(CODE_NONE, 3'h3, 3'h0);
        overcurrent_limit_pin = 1'b0;
        // trips on unarmed switches and interrupted trips latch nothing
        hb_host_model_i.command(3'h0, 3'h1);
        step(60);
        ds_trip_hi = 3'($random(seed));
        ds_trip_lo = {2'($random(seed)), 1'b0};
        step(40);
        ds_trip_hi = 3'h0;
        ds_trip_lo = 3'h0;
        expect_out(CODE_NONE, 3'h0, 3'h1);
        for (int k = 0; k < 2; k++) begin
            ds_trip_lo = 3'h1;
            step(SC - 4);
            ds_trip_lo = 3'h0;
            step(8);
        end
        expect_out(CODE_NONE, 3'h0, 3'h1);
        ds_trip_lo = 3'h1;
        temp_over_sense = 1'b1;
        step(SC + 20);
        ds_trip_lo = 3'h0;
        expect_out(CODE_SCOC, 3'h0, 3'h0);
        temp_over_sense = 1'b0;
        hb_host_model_i.set_enable(r1[0] ? 2'h2 : 2'h1);
        step(10);
        hb_host_model_i.set_enable(2'h3);
        step(30);
        expect_out(CODE_SCOC, 3'h0, 3'h0);
        hb_host_model_i.set_enable(2'h1);
        temp_over_sense = 1'b1;
        step(RES + 10);
        expect_out(CODE_OTOV, 3'h0, 3'h0);
        temp_over_sense = 1'b0;
        hb_host_model_i.set_enable(2'h3);
        step(60);
        expect_out(CODE_NONE, 3'h0, 3'h1);
        for (int k = 1; k < 3; k++) begin
            pump_buffer_caps = 2'(k);
            step(30);
            expect_out(CODE_UV, 3'h0, 3'h0);
            pump_buffer_caps = 2'h0;
            step(60);
            expect_out(CODE_NONE, 3'h0, 3'h1);
        end
        // each supply sense alone latches the shutdown
        for (int k = 0; k < 2; k++) begin
            {vs_over_sense, bridge_supply_sense} = 2'(k + 1);
            step(OV + 20);
            {vs_over_sense, bridge_supply_sense} = 2'h0;
            step(10);
            expect_out(CODE_UV, 3'h0, 3'h0, 1'b0);
            hb_host_model_i.set_enable(2'h0);
            step(RES + 10);
            hb_host_model_i.set_enable(2'h3);
            step(60);
            expect_out(CODE_NONE, 3'h0, 3'h1);
        end
        hb_host_model_i.command(3'h0, 3'h0);
        wake_control_in = 1'b0;
        step(20);
        expect_out(CODE_NONE, 3'h0, 3'h0, 1'b1, 1'b1);
        step(5);
        conclude();
    end
endmodule
